// File: core/npg_pkg.sv
// package for the nvm protection, security and interrupt block
// assumes a 32-bit AXI4-Lite register bus and a 16-bit global address space
package npg_pkg;
  // register byte offsets
  localparam logic [7:0] NPG_OFS_STATUS = 8'h00;
  localparam logic [7:0] NPG_OFS_CONFIG = 8'h04;
  localparam logic [7:0] NPG_OFS_ERRSTAT = 8'h08;
  localparam logic [7:0] NPG_OFS_ERRCFG = 8'h0C;
  localparam logic [7:0] NPG_OFS_FGUARD = 8'h10;
  localparam logic [7:0] NPG_OFS_EGUARD = 8'h14;
  localparam logic [7:0] NPG_OFS_LOCK = 8'h18;
  // field positions
  localparam int NPG_BIT_CMD_DONE = 7;
  localparam int NPG_BIT_VIOL = 5;
  localparam int NPG_BIT_CMD_IE = 7;
  localparam int NPG_BIT_DFAULT = 1;
  localparam int NPG_BIT_SFAULT = 0;
  localparam int NPG_BIT_OPEN = 7;
  localparam int NPG_BIT_HDIS = 5;
  localparam int NPG_BIT_LDIS = 2;
  localparam int NPG_BIT_EOPEN = 7;
  // configuration field addresses
  localparam logic [15:0] NPG_CFG_KEY = 16'hFF70;
  localparam logic [15:0] NPG_CFG_RSVD = 16'hFF78;
  localparam logic [15:0] NPG_CFG_FGUARD = 16'hFF7C;
  localparam logic [15:0] NPG_CFG_EGUARD = 16'hFF7D;
  localparam logic [15:0] NPG_CFG_NVOPT = 16'hFF7E;
  localparam logic [15:0] NPG_CFG_LOCK = 16'hFF7F;
  localparam logic [7:0] NPG_RSVD_FILL = 8'hFF;
  // address map of the protected regions
  localparam logic [15:0] NPG_FLASH_BASE = 16'h8000;
  localparam logic [15:0] NPG_FLASH_TOP = 16'hFFFF;
  localparam logic [15:0] NPG_EE_BASE = 16'h3100;
  localparam int NPG_EE_UNIT = 32;
  // base of the high range and top of the low range, by size code
  localparam logic [15:0] NPG_HI_BASE0 = 16'hF800;
  localparam logic [15:0] NPG_HI_BASE1 = 16'hF000;
  localparam logic [15:0] NPG_HI_BASE2 = 16'hE000;
  localparam logic [15:0] NPG_HI_BASE3 = 16'hC000;
  localparam logic [15:0] NPG_LO_TOP0 = 16'h83FF;
  localparam logic [15:0] NPG_LO_TOP1 = 16'h87FF;
  localparam logic [15:0] NPG_LO_TOP2 = 16'h8FFF;
  localparam logic [15:0] NPG_LO_TOP3 = 16'h9FFF;
  localparam logic [1:0] NPG_UNSECURE = 2'b10;
  // reset values
  localparam logic [7:0] NPG_RST_BYTE = 8'h00;
  localparam logic [1:0] NPG_RESP_OKAY = 2'b00;
  localparam logic [1:0] NPG_RESP_SLVERR = 2'b10;
  // nonvolatile bytes read from the configuration field at reset
  typedef struct packed {
    logic [7:0] fguard;
    logic [7:0] eguard;
    logic [7:0] nvopt;
    logic [7:0] lock;
  } npg_cfg_s;
  typedef enum logic {NPG_LOAD, NPG_RUN} npg_phase_e;

  // allowed flash scenario changes, one bit per target scenario
  function automatic logic npg_step_ok(input logic [2:0] from, input logic [2:0] to);
    logic [7:0] mask;
    mask = 8'h00;
    unique case (from)
      3'd0: mask = 8'h0F;
      3'd1: mask = 8'h0A;
      3'd2: mask = 8'h0C;
      3'd3: mask = 8'h08;
      3'd4: mask = 8'h18;
      3'd5: mask = 8'h3C;
      3'd6: mask = 8'h5A;
      3'd7: mask = 8'hFF;
    endcase
    return mask[to];
  endfunction

  function automatic logic [2:0] npg_scen(input logic [7:0] g);
    return {g[NPG_BIT_OPEN], g[NPG_BIT_HDIS], g[NPG_BIT_LDIS]};
  endfunction
endpackage

// File: core/npg_range.sv
// address decoder for flash and eeprom protected ranges
// assumes guard registers held stable by the caller
`timescale 1ns/1ps
`default_nettype none
module npg_range (
  // guard settings
  input wire logic [7:0] fguard,
  input wire logic [7:0] eguard,
  // address under test
  input wire logic [15:0] addr,
  // verdict
  output logic prot
);
  import npg_pkg::*;
  logic [15:0] high_base;
  logic [15:0] low_top;
  logic [15:0] ee_top;
  logic in_flash;
  logic in_high;
  logic in_low;
  logic hit_rng;
  logic f_prot;
  logic e_prot;

  always_comb
  begin
    unique case (fguard[4:3])
      2'b00: high_base = NPG_HI_BASE0;
      2'b01: high_base = NPG_HI_BASE1;
      2'b10: high_base = NPG_HI_BASE2;
      2'b11: high_base = NPG_HI_BASE3;
    endcase
    unique case (fguard[1:0])
      2'b00: low_top = NPG_LO_TOP0;
      2'b01: low_top = NPG_LO_TOP1;
      2'b10: low_top = NPG_LO_TOP2;
      2'b11: low_top = NPG_LO_TOP3;
    endcase
  end

  assign in_flash = addr >= NPG_FLASH_BASE;
  assign in_high = addr >= high_base;
  assign in_low = in_flash && addr <= low_top;
  assign hit_rng = (!fguard[NPG_BIT_HDIS] && in_high) || (!fguard[NPG_BIT_LDIS] && in_low);
  // open: cleared disable protects; closed: cleared disable exempts
  assign f_prot = in_flash && (fguard[NPG_BIT_OPEN] ? hit_rng : !hit_rng);
  assign ee_top = 16'(NPG_EE_BASE + NPG_EE_UNIT * (eguard[2:0] + 1) - 1);
  assign e_prot = !eguard[NPG_BIT_EOPEN] && addr >= NPG_EE_BASE && addr <= ee_top;
  assign prot = f_prot || e_prot;
endmodule
`default_nettype wire

// File: core/npg_core.sv
// nvm protection, security and interrupt request logic with AXI4-Lite registers
// assumes config field bytes are valid on cfg while rst_n is low and at release
`timescale 1ns/1ps
`default_nettype none
module npg_core (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // configuration field bytes
  input wire npg_pkg::npg_cfg_s cfg,
  // memory controller events
  input wire logic cmd_complete,
  input wire logic double_fault,
  input wire logic single_fault,
  input wire logic key_match,
  // program or erase check
  input wire logic pe_req,
  input wire logic [15:0] pe_addr,
  output logic pe_allow,
  output logic pe_deny,
  // results
  output logic cmd_launch,
  output logic irq_cmd,
  output logic irq_err,
  output logic [1:0] lock_bits,
  output logic secured
);
  import npg_pkg::*;
  npg_phase_e phase;
  logic cmd_done_flag;
  logic guard_violation_flag;
  logic cmd_done_irq_en;
  logic double_fault_flag;
  logic single_fault_flag;
  logic double_fault_irq_en;
  logic single_fault_irq_en;
  logic [7:0] flash_guard_reg;
  logic [7:0] eeprom_guard_reg;
  logic [7:0] lock_state_reg;
  logic aw_got;
  logic w_got;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] s_q;
  logic do_wr;
  logic [7:0] wb;
  logic hit_prot;
  logic wr_launch;
  logic [31:0] next_rdata;
  logic rd_map;

  npg_range u_range (
    .fguard(flash_guard_reg),
    .eguard(eeprom_guard_reg),
    .addr(pe_addr),
    .prot(hit_prot)
  );

  assign do_wr = aw_got && w_got && !bvalid;
  assign wb = s_q[0] ? w_q[7:0] : NPG_RST_BYTE;
  assign wr_launch = do_wr && s_q[0] && aw_q == NPG_OFS_STATUS
    && w_q[NPG_BIT_CMD_DONE] && cmd_done_flag;

  // one-shot capture of the configuration field after reset release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      phase <= NPG_LOAD;
    else
      phase <= NPG_RUN;
  end

  // write address and data taken in either order
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_q <= NPG_RST_BYTE;
      w_q <= '0;
      s_q <= '0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= NPG_RESP_OKAY;
    end
    else
    begin
      awready <= phase == NPG_RUN && !aw_got && !(awvalid && awready) && !bvalid;
      wready <= phase == NPG_RUN && !w_got && !(wvalid && wready) && !bvalid;
      if (awvalid && awready)
      begin
        aw_got <= 1'b1;
        aw_q <= {awaddr[7:2], 2'b00};
      end
      if (wvalid && wready)
      begin
        w_got <= 1'b1;
        w_q <= wdata;
        s_q <= wstrb;
      end
      if (do_wr)
      begin
        bvalid <= 1'b1;
        bresp <= aw_q > NPG_OFS_LOCK ? NPG_RESP_SLVERR : NPG_RESP_OKAY;
        aw_got <= 1'b0;
        w_got <= 1'b0;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // command-done flag, launch pulse; completion beats launch
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_done_flag <= 1'b1;
      cmd_launch <= 1'b0;
    end
    else
    begin
      cmd_launch <= wr_launch;
      if (cmd_complete)
        cmd_done_flag <= 1'b1;
      else if (wr_launch)
        cmd_done_flag <= 1'b0;
    end
  end

  // fault and violation flags, write one to clear, set wins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      double_fault_flag <= 1'b0;
      single_fault_flag <= 1'b0;
      guard_violation_flag <= 1'b0;
    end
    else
    begin
      if (double_fault)
        double_fault_flag <= 1'b1;
      else if (do_wr && aw_q == NPG_OFS_ERRSTAT && wb[NPG_BIT_DFAULT])
        double_fault_flag <= 1'b0;
      if (single_fault)
        single_fault_flag <= 1'b1;
      else if (do_wr && aw_q == NPG_OFS_ERRSTAT && wb[NPG_BIT_SFAULT])
        single_fault_flag <= 1'b0;
      if (pe_req && hit_prot)
        guard_violation_flag <= 1'b1;
      else if (do_wr && aw_q == NPG_OFS_STATUS && wb[NPG_BIT_VIOL])
        guard_violation_flag <= 1'b0;
    end
  end

  // program or erase verdict
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pe_allow <= 1'b0;
      pe_deny <= 1'b0;
    end
    else
    begin
      pe_allow <= pe_req && !hit_prot;
      pe_deny <= pe_req && hit_prot;
    end
  end

  // interrupt enables
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_done_irq_en <= 1'b0;
      double_fault_irq_en <= 1'b0;
      single_fault_irq_en <= 1'b0;
    end
    else if (do_wr && s_q[0])
    begin
      if (aw_q == NPG_OFS_CONFIG)
        cmd_done_irq_en <= wb[NPG_BIT_CMD_IE];
      if (aw_q == NPG_OFS_ERRCFG)
      begin
        double_fault_irq_en <= wb[NPG_BIT_DFAULT];
        single_fault_irq_en <= wb[NPG_BIT_SFAULT];
      end
    end
  end

  // interrupt requests
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_cmd <= 1'b0;
      irq_err <= 1'b0;
    end
    else
    begin
      irq_cmd <= cmd_done_flag && cmd_done_irq_en;
      irq_err <= (double_fault_flag && double_fault_irq_en)
        || (single_fault_flag && single_fault_irq_en);
    end
  end

  // guard registers: loaded at reset, then only tightened except the flash size fields
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flash_guard_reg <= NPG_RST_BYTE;
      eeprom_guard_reg <= NPG_RST_BYTE;
    end
    else if (phase == NPG_LOAD)
    begin
      flash_guard_reg <= cfg.fguard;
      eeprom_guard_reg <= cfg.eguard;
    end
    else if (do_wr && s_q[0])
    begin
      if (aw_q == NPG_OFS_FGUARD && npg_step_ok(npg_scen(flash_guard_reg), npg_scen(wb)))
        flash_guard_reg <= wb;
      // eeprom guard may close, and grow while closed
      if (aw_q == NPG_OFS_EGUARD && (wb[NPG_BIT_EOPEN] ? eeprom_guard_reg[NPG_BIT_EOPEN]
          : (eeprom_guard_reg[NPG_BIT_EOPEN] || wb[2:0] >= eeprom_guard_reg[2:0])))
        eeprom_guard_reg <= wb;
    end
  end

  // lock state: reset load only, key match unsecures
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lock_state_reg <= NPG_RST_BYTE;
      lock_bits <= NPG_RST_BYTE[1:0];
      secured <= 1'b1;
    end
    else
    begin
      if (phase == NPG_LOAD)
        lock_state_reg <= cfg.lock;
      else if (key_match)
        lock_state_reg[1:0] <= NPG_UNSECURE;
      lock_bits <= lock_state_reg[1:0];
      secured <= phase == NPG_LOAD || lock_state_reg[1:0] != NPG_UNSECURE;
    end
  end

  // read data mux
  always_comb
  begin
    next_rdata = '0;
    rd_map = 1'b1;
    unique case ({araddr[7:2], 2'b00})
      NPG_OFS_STATUS:
      begin
        next_rdata[NPG_BIT_CMD_DONE] = cmd_done_flag;
        next_rdata[NPG_BIT_VIOL] = guard_violation_flag;
      end
      NPG_OFS_CONFIG: next_rdata[NPG_BIT_CMD_IE] = cmd_done_irq_en;
      NPG_OFS_ERRSTAT: next_rdata[1:0] = {double_fault_flag, single_fault_flag};
      NPG_OFS_ERRCFG: next_rdata[1:0] = {double_fault_irq_en, single_fault_irq_en};
      NPG_OFS_FGUARD: next_rdata[7:0] = flash_guard_reg;
      NPG_OFS_EGUARD: next_rdata[7:0] = eeprom_guard_reg;
      NPG_OFS_LOCK: next_rdata[7:0] = lock_state_reg;
      default: rd_map = 1'b0;
    endcase
  end

  // read channel
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= NPG_RESP_OKAY;
    end
    else
    begin
      arready <= phase == NPG_RUN && !rvalid && !(arvalid && arready);
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rdata <= next_rdata;
        rresp <= rd_map ? NPG_RESP_OKAY : NPG_RESP_SLVERR;
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  irq_cmd_a: assert property (irq_cmd == $past(cmd_done_flag && cmd_done_irq_en))
    else $error("command irq mismatch");
  irq_err_a: assert property (double_fault && double_fault_irq_en |-> ##2 irq_err)
    else $error("error irq missing");
  guard_load_a: assert property ($fell(phase == NPG_LOAD) |-> flash_guard_reg == $past(cfg.fguard))
    else $error("flash guard not loaded");
  guard_step_a: assert property ($changed(flash_guard_reg) && $past(phase) == NPG_RUN
    |-> npg_step_ok(npg_scen($past(flash_guard_reg)), npg_scen(flash_guard_reg)))
    else $error("illegal scenario change");
  open_all_a: assert property (npg_scen(flash_guard_reg) == 3'b111
    && pe_req && pe_addr >= NPG_FLASH_BASE |=> pe_allow)
    else $error("unprotected flash denied");
  full_prot_a: assert property (npg_scen(flash_guard_reg) == 3'b011
    && pe_req && pe_addr >= NPG_FLASH_BASE |=> pe_deny && guard_violation_flag)
    else $error("full protection leak");
  ee_load_a: assert property ($fell(phase == NPG_LOAD) |-> eeprom_guard_reg == $past(cfg.eguard))
    else $error("eeprom guard not loaded");
  lock_hold_a: assert property (phase == NPG_RUN && !key_match |=> $stable(lock_state_reg))
    else $error("lock state changed");
  key_open_a: assert property (phase == NPG_RUN && key_match |-> ##2 !secured)
    else $error("key match did not unsecure");
  launch_a: assert property (wr_launch && !cmd_complete |=> cmd_launch && !cmd_done_flag)
    else $error("launch did not clear done flag");
  read_guard_a: assert property (arvalid && arready && {araddr[7:2], 2'b00} == NPG_OFS_FGUARD
    |=> rdata[7:0] == $past(flash_guard_reg))
    else $error("guard readback wrong");

  launch_c: cover property (cmd_launch ##[1:20] cmd_done_flag);
  viol_c: cover property (pe_deny);
  step_c: cover property (phase == NPG_RUN && $changed(flash_guard_reg));
  unlock_c: cover property ($fell(secured));
endmodule
`default_nettype wire

// File: verif/tb_npg_core.sv
// self-checking bench for npg_core: guard ranges, scenario changes, irq, lock
// assumes the core answers on AXI4-Lite and loads cfg at reset release
`timescale 1ns/1ps
`default_nettype none
module tb_npg_core;
  import npg_pkg::*;
  typedef struct packed {
    logic [7:0] fg;
    logic [7:0] eg;
    logic [15:0] a;
    logic dn;
  } npg_row_s;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, lock_bits;
  npg_cfg_s cfg = '{8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [3:0] ev = 4'h0;
  logic pe_req = 1'b0;
  logic [15:0] pe_addr = 16'h0;
  logic pe_allow, pe_deny, cmd_launch, irq_cmd, irq_err, secured;
  int mismatches = 0;
  int n_tests = 0;
  int n_launch = 0;
  logic [31:0] rd;
  logic [1:0] rs;
  logic d, al;
  logic [7:0] okm [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF};
  npg_row_s rows [19] = '{
    '{8'hA4, 8'h80, 16'h8000, 1'b0}, '{8'h84, 8'h80, 16'hF800, 1'b1},
    '{8'h84, 8'h80, 16'hF7FF, 1'b0}, '{8'h9C, 8'h80, 16'hC000, 1'b1},
    '{8'h9C, 8'h80, 16'hBFFF, 1'b0}, '{8'hA0, 8'h80, 16'h83FF, 1'b1},
    '{8'hA0, 8'h80, 16'h8400, 1'b0}, '{8'hA3, 8'h80, 16'h9FFF, 1'b1},
    '{8'hA3, 8'h80, 16'hA000, 1'b0}, '{8'h24, 8'h80, 16'hFFFF, 1'b1},
    '{8'h24, 8'h80, 16'h8000, 1'b1}, '{8'h00, 8'h80, 16'h8000, 1'b0},
    '{8'h00, 8'h80, 16'h8400, 1'b1}, '{8'h00, 8'h80, 16'hF800, 1'b0},
    '{8'hA4, 8'h00, 16'h311F, 1'b1}, '{8'hA4, 8'h00, 16'h3120, 1'b0},
    '{8'hA4, 8'h07, 16'h31FF, 1'b1}, '{8'hA4, 8'h07, 16'h3200, 1'b0},
    '{8'hA4, 8'h87, 16'h3100, 1'b0}};

  always #5 clk = ~clk;
  always @(posedge clk) if (cmd_launch === 1'b1) n_launch++;

  npg_core i_dut (.clk(clk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .cfg(cfg), .cmd_complete(ev[2]),
    .double_fault(ev[1]), .single_fault(ev[0]), .key_match(ev[3]),
    .pe_req(pe_req), .pe_addr(pe_addr), .pe_allow(pe_allow), .pe_deny(pe_deny),
    .cmd_launch(cmd_launch), .irq_cmd(irq_cmd), .irq_err(irq_err),
    .lock_bits(lock_bits), .secured(secured));

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // guard byte for a scenario number, size fields 00
  function automatic logic [7:0] sb(input logic [2:0] s);
    return {s[2], 1'b0, s[1], 2'b00, s[0], 2'b00};
  endfunction

  task automatic hang();
    mismatches++;
    wrap_up();
  endtask

  task automatic rst(input logic [7:0] fg, input logic [7:0] eg, input logic [7:0] lk);
    @(posedge clk) rst_n <= 1'b0;
    cfg <= '{fg, eg, 8'hFF, lk};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] dt, output logic [1:0] r);
    int i;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= dt;
    bready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (i == 50) hang();
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] r);
    int i;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        dt = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (i == 50) hang();
  endtask

  // one-cycle event pulse, then let the registered outputs settle
  task automatic evp(input int k);
    @(posedge clk) ev[k] <= 1'b1;
    @(posedge clk) ev[k] <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic pechk(input logic [15:0] a, output logic dn, output logic ok);
    int i;
    @(posedge clk);
    pe_req <= 1'b1;
    pe_addr <= a;
    @(posedge clk) pe_req <= 1'b0;
    for (i = 0; i < 5; i++)
    begin
      #1;
      if (pe_allow === 1'b1 || pe_deny === 1'b1) break;
      @(posedge clk);
    end
    dn = pe_deny;
    ok = pe_allow;
    if (i == 5) hang();
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    foreach (rows[k])
    begin
      rst(rows[k].fg, rows[k].eg, 8'hFF);
      pechk(rows[k].a, d, al);
      chk(d, rows[k].dn);
      chk(al, !rows[k].dn);
    end
    $display("test ranges done");
    for (int f = 0; f < 8; f++)
      for (int t = 0; t < 8; t++)
      begin
        rst(sb(f[2:0]), 8'h80, 8'hFF);
        axw(NPG_OFS_FGUARD, {24'h0, sb(t[2:0])}, rs);
        axr(NPG_OFS_FGUARD, rd, rs);
        chk(rd & 32'hA4, okm[f][t] ? sb(t[2:0]) : sb(f[2:0]));
      end
    $display("test scenario steps done");
    rst(8'h9B, 8'h05, 8'hFF);
    axr(NPG_OFS_FGUARD, rd, rs);
    chk(rd & 32'hBF, 32'h9B);
    axr(NPG_OFS_EGUARD, rd, rs);
    chk(rd & 32'h87, 32'h05);
    axw(NPG_OFS_CONFIG, 32'h80, rs);
    settle();
    chk(irq_cmd, 1'b1);
    axw(NPG_OFS_STATUS, 32'h80, rs);
    settle();
    chk(n_launch, 1);
    chk(irq_cmd, 1'b0);
    evp(2);
    chk(irq_cmd, 1'b1);
    axw(NPG_OFS_CONFIG, 32'h00, rs);
    settle();
    chk(irq_cmd, 1'b0);
    axw(NPG_OFS_ERRCFG, 32'h02, rs);
    evp(0);
    chk(irq_err, 1'b0);
    evp(1);
    chk(irq_err, 1'b1);
    axw(NPG_OFS_ERRSTAT, 32'h03, rs);
    axw(NPG_OFS_ERRCFG, 32'h01, rs);
    settle();
    chk(irq_err, 1'b0);
    evp(0);
    chk(irq_err, 1'b1);
    $display("test irq done");
    rst(8'h24, 8'h80, 8'hFF);
    axw(NPG_OFS_EGUARD, 32'h03, rs);
    axw(NPG_OFS_EGUARD, 32'h01, rs);
    axw(NPG_OFS_EGUARD, 32'h83, rs);
    axr(NPG_OFS_EGUARD, rd, rs);
    chk(rd & 32'h87, 32'h03);
    pechk(16'hC000, d, al);
    axr(NPG_OFS_STATUS, rd, rs);
    chk(rd[NPG_BIT_VIOL], 1'b1);
    axw(NPG_OFS_STATUS, 32'h20, rs);
    axr(NPG_OFS_STATUS, rd, rs);
    chk(rd[NPG_BIT_VIOL], 1'b0);
    axw(8'h1C, 32'h0, rs);
    chk(rs, NPG_RESP_SLVERR);
    axr(8'h1C, rd, rs);
    chk(rd, 32'h0);
    chk(rs, NPG_RESP_SLVERR);
    $display("test violation done");
    settle();
    chk({lock_bits, secured}, 3'b111);
    @(posedge clk) cfg.lock <= 8'hFE;
    axw(NPG_OFS_LOCK, 32'h02, rs);
    chk(rs, NPG_RESP_OKAY);
    settle();
    chk({lock_bits, secured}, 3'b111);
    evp(3);
    chk({lock_bits, secured}, {NPG_UNSECURE, 1'b0});
    rst(8'hFF, 8'hFF, 8'hFE);
    settle();
    axr(NPG_OFS_LOCK, rd, rs);
    chk(rd & 32'h3, 32'h2);
    chk(secured, 1'b0);
    $display("test lock done");
    wrap_up();
  end
endmodule
`default_nettype wire
